// ### rtl/hpc_defs.vh
`ifndef HPC_DEFS_VH
`define HPC_DEFS_VH
// ************************************************************
// Widths and reset values
// ************************************************************
`define HPC_NUM_OUT 8
`define HPC_IRQ_STRETCH 8'h04
`define HPC_MODE_I2C 1'b1
`define HPC_MODE_SPI 1'b0
`define HPC_PULL_HIGH 1'b1
`define HPC_PULL_LOW 1'b0
`define HPC_OUT_ALL 8'hff
`define HPC_OUT_NONE 8'h00
`define HPC_ADDR_BIT_HI 1
`define HPC_ADDR_BIT_LO 0
`define HPC_ADDR_NONE 2'h0
`define HPC_SYNC_INIT 8'hc9
`define HPC_WARM_NONE 2'h0
`define HPC_WARM_DONE 2'h3
`define HPC_IRQ_IDLE 8'h00
`endif

// ### rtl/hpc_sync.v
`include "hpc_defs.vh"
// ************************************************************
// Two-stage synchroniser, one per bit
// ************************************************************
module hpc_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   // Clock and reset
   input wire clock_i,
   input wire rst_i,
   // Data
   input wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         always @(posedge clock_i) begin
            if (rst_i) begin
               meta_ff[g] <= INIT[g];
               sync_ff[g] <= INIT[g];
            end else begin
               meta_ff[g] <= async_i[g];
               sync_ff[g] <= meta_ff[g];
            end
         end
      end
   endgenerate
   assign sync_o = sync_ff;
endmodule

// ### rtl/hpc_pin_ctrl.v
// What this block does
// - Mode pin high selects I2C, low SPI
// - Undriven mode pin reads high, I2C
// - Data pin: I2C/3-wire bidir, 4-wire input
// - Pin two: address high or SPI out
// - Host clock pin clocks both modes
// - Pin three: address low or chip select
// - Interrupt driven low on status change
// - Reset low restores maps, outputs, IRQ; relatches mode
// - Clock outputs disabled during reset
// - First enable low enables, pulled low
// - First enable covers all, configurable subset
// - Second enable inert until configured
`include "hpc_defs.vh"
module hpc_pin_ctrl (
   // Clock and reset
   input wire clock_i,
   input wire rst_i,
   // Mode and control pins
   input wire mode_sel_i,
   input wire mode_sel_driven_i,
   input wire device_reset_n_i,
   input wire output_enable_first_n_i,
   input wire output_enable_first_driven_i,
   input wire output_enable_second_n_i,
   // Serial clock and data pins
   input wire serial_clock_i,
   input wire data_i,
   output reg data_o,
   output reg data_oe_n_o,
   // Pin two
   input wire addr_hi_or_serial_out_i,
   output reg addr_hi_or_serial_out_o,
   output reg addr_hi_or_serial_out_oe_n_o,
   // Pin three
   input wire addr_lo_or_chip_select_n_i,
   input wire addr_lo_or_chip_select_driven_i,
   // Status pin
   output reg status_change_irq_n_o,
   // Protocol engine data and configuration
   input wire spi_four_wire_i,
   input wire eng_data_out_i,
   input wire eng_data_oe_i,
   input wire eng_sdo_i,
   input wire status_event_i,
   // Enable maps
   input wire [`HPC_NUM_OUT-1:0] oe_first_map_i,
   input wire oe_first_map_wr_i,
   input wire [`HPC_NUM_OUT-1:0] oe_second_map_i,
   input wire oe_second_map_wr_i,
   // Engine view of the pins
   output reg i2c_mode_o,
   output reg serial_clock_o,
   output reg serial_clock_rise_o,
   output reg serial_clock_fall_o,
   output reg data_in_o,
   output reg chip_select_n_o,
   output reg [1:0] i2c_addr_low_o,
   output reg core_reset_o,
   // Clock output enables
   output reg [`HPC_NUM_OUT-1:0] clock_out_en_o
);
   // ************************************************************
   // Pull levels
   // ************************************************************
   // Undriven pins take their internal pull level before syncing
   wire mode_pin;
   wire oe1_pin;
   wire cs_pin;
   wire [7:0] raw;
   wire [7:0] syn;
   assign mode_pin = mode_sel_driven_i ? mode_sel_i : `HPC_PULL_HIGH;
   assign oe1_pin = output_enable_first_driven_i ? output_enable_first_n_i : `HPC_PULL_LOW;
   assign cs_pin = addr_lo_or_chip_select_driven_i ? addr_lo_or_chip_select_n_i : `HPC_PULL_HIGH;
   assign raw = {mode_pin, device_reset_n_i, oe1_pin, output_enable_second_n_i,
                 serial_clock_i, data_i, addr_hi_or_serial_out_i, cs_pin};

   // ************************************************************
   // Synchronisers
   // ************************************************************
   // Every pin passes two flops before any logic reads it
   hpc_sync #(
      .W(8),
      .INIT(`HPC_SYNC_INIT)
   ) u_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .async_i(raw),
      .sync_o(syn)
   );

   wire s_mode = syn[7];
   wire s_rst_n = syn[6];
   wire s_oe1_n = syn[5];
   wire s_oe2_n = syn[4];
   wire s_sclk = syn[3];
   wire s_data = syn[2];
   wire s_ahi = syn[1];
   wire s_cs = syn[0];

   // ************************************************************
   // Reset and mode latch
   // ************************************************************
   reg mode_ff;
   reg sclk_prev_ff;
   reg [1:0] sclk_warm_ff;
   wire sclk_edges_ok;
   reg [`HPC_NUM_OUT-1:0] map1_ff;
   reg [`HPC_NUM_OUT-1:0] map2_ff;
   reg [7:0] irq_cnt_ff;
   wire dev_rst = rst_i | ~s_rst_n;
   wire [`HPC_NUM_OUT-1:0] nxt_en;

   // Mode is caught while reset is held so a mid-transfer pin change cannot flip the port
   always @(posedge clock_i) begin
      if (rst_i) begin
         mode_ff <= `HPC_MODE_I2C;
      end else if (~s_rst_n) begin
         mode_ff <= s_mode;
      end
   end

   // ************************************************************
   // Enable maps
   // ************************************************************
   // enable maps
   always @(posedge clock_i) begin
      if (dev_rst) begin
         map1_ff <= `HPC_OUT_ALL;
         map2_ff <= `HPC_OUT_NONE;
      end else begin
         if (oe_first_map_wr_i) begin
            map1_ff <= oe_first_map_i;
         end
         if (oe_second_map_wr_i) begin
            map2_ff <= oe_second_map_i;
         end
      end
   end

   // ************************************************************
   // Output enables
   // ************************************************************
   // Either pin can turn off an output mapped to it, so a high pin always wins
   genvar g;
   generate
      for (g = 0; g < `HPC_NUM_OUT; g = g + 1) begin : g_oe
         assign nxt_en[g] = ~(map1_ff[g] & s_oe1_n) & ~(map2_ff[g] & s_oe2_n);
      end
   endgenerate

   // ************************************************************
   // Registered enables
   // ************************************************************
   // Registered so every enable leaving the block comes from a flop
   always @(posedge clock_i) begin
      if (dev_rst) begin
         clock_out_en_o <= `HPC_OUT_NONE;
      end else begin
         clock_out_en_o <= nxt_en;
      end
   end

   // ************************************************************
   // Core reset and mode view
   // ************************************************************
   // The engine and its view of the mode leave reset on the same edge
   always @(posedge clock_i) begin
      if (dev_rst) begin
         core_reset_o <= 1'b1;
         i2c_mode_o <= `HPC_MODE_I2C;
      end else begin
         core_reset_o <= 1'b0;
         i2c_mode_o <= mode_ff;
      end
   end

   // ************************************************************
   // Serial clock and its edges
   // ************************************************************
   // The synchroniser leaves reset holding its preset, not the pin, so edges are
   // ignored until it has flushed; without this a false edge could follow reset
   always @(posedge clock_i) begin
      if (rst_i) begin
         sclk_warm_ff <= `HPC_WARM_NONE;
      end else if (sclk_warm_ff != `HPC_WARM_DONE) begin
         sclk_warm_ff <= sclk_warm_ff + 2'h1;
      end
   end

   assign sclk_edges_ok = (sclk_warm_ff == `HPC_WARM_DONE);

   // Tracks the pin through a device reset, so leaving it shows no edge
   always @(posedge clock_i) begin
      sclk_prev_ff <= s_sclk;
   end

   always @(posedge clock_i) begin
      if (dev_rst) begin
         serial_clock_o <= 1'b0;
         serial_clock_rise_o <= 1'b0;
         serial_clock_fall_o <= 1'b0;
      end else begin
         serial_clock_o <= s_sclk;
         serial_clock_rise_o <= sclk_edges_ok & s_sclk & ~sclk_prev_ff;
         serial_clock_fall_o <= sclk_edges_ok & ~s_sclk & sclk_prev_ff;
      end
   end

   // ************************************************************
   // Data in, chip select and address
   // ************************************************************
   // In I2C the address pins are only read, never driven
   always @(posedge clock_i) begin
      if (dev_rst) begin
         data_in_o <= 1'b1;
         chip_select_n_o <= 1'b1;
         i2c_addr_low_o <= `HPC_ADDR_NONE;
      end else begin
         data_in_o <= s_data;
         chip_select_n_o <= (mode_ff == `HPC_MODE_I2C) ? 1'b1 : s_cs;
         i2c_addr_low_o[`HPC_ADDR_BIT_HI] <= (mode_ff == `HPC_MODE_I2C) ? s_ahi : 1'b0;
         i2c_addr_low_o[`HPC_ADDR_BIT_LO] <= (mode_ff == `HPC_MODE_I2C) ? s_cs : 1'b0;
      end
   end

   // ************************************************************
   // Shared data pin
   // ************************************************************
   // In 4-wire SPI the pin is input only; data leaves on pin two
   always @(posedge clock_i) begin
      if (dev_rst) begin
         data_o <= 1'b0;
         data_oe_n_o <= 1'b1;
      end else begin
         if (mode_ff == `HPC_MODE_I2C) begin
            // Open drain: only ever pull low
            data_o <= 1'b0;
            data_oe_n_o <= ~(eng_data_oe_i & ~eng_data_out_i);
         end else if (spi_four_wire_i) begin
            data_o <= 1'b0;
            data_oe_n_o <= 1'b1;
         end else begin
            data_o <= eng_data_out_i;
            data_oe_n_o <= ~(eng_data_oe_i & ~s_cs);
         end
      end
   end

   // ************************************************************
   // Pin two
   // ************************************************************
   // Driven only while selected, so several parts can share one data-out wire
   always @(posedge clock_i) begin
      if (dev_rst) begin
         addr_hi_or_serial_out_o <= 1'b0;
         addr_hi_or_serial_out_oe_n_o <= 1'b1;
      end else begin
         if (mode_ff == `HPC_MODE_SPI && spi_four_wire_i) begin
            addr_hi_or_serial_out_o <= eng_sdo_i;
            addr_hi_or_serial_out_oe_n_o <= s_cs;
         end else begin
            addr_hi_or_serial_out_o <= 1'b0;
            addr_hi_or_serial_out_oe_n_o <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Status interrupt
   // ************************************************************
   // Stretched so a one-cycle event is wide enough for a slow host to see
   // A new event restarts the stretch, so a burst keeps the pin low throughout
   always @(posedge clock_i) begin
      if (dev_rst) begin
         irq_cnt_ff <= `HPC_IRQ_IDLE;
      end else if (status_event_i) begin
         irq_cnt_ff <= `HPC_IRQ_STRETCH;
      end else if (irq_cnt_ff != `HPC_IRQ_IDLE) begin
         irq_cnt_ff <= irq_cnt_ff - 8'h01;
      end
   end

   // ************************************************************
   // Interrupt pin
   // ************************************************************
   always @(posedge clock_i) begin
      if (dev_rst) begin
         status_change_irq_n_o <= 1'b1;
      end else begin
         status_change_irq_n_o <= ~(status_event_i | (irq_cnt_ff != `HPC_IRQ_IDLE));
      end
   end
endmodule

// ### tb/hpc_pin_ctrl_properties.sv
// ****
// Port checker
// ****
module hpc_pin_ctrl_properties (
   // Watched ports
   input wire clock_i,
   input wire rst_i,
   input wire status_event_i,
   input wire data_o,
   input wire data_oe_n_o,
   input wire addr_hi_or_serial_out_oe_n_o,
   input wire status_change_irq_n_o,
   input wire i2c_mode_o,
   input wire serial_clock_o,
   input wire serial_clock_rise_o,
   input wire core_reset_o,
   input wire [7:0] clock_out_en_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // Two cycles, so a one-cycle lag between outputs is tolerated
   sequence held_rst;
      core_reset_o [*2];
   endsequence
   en_reset_a: assert property (held_rst |-> clock_out_en_o == 8'h00) else $error("out on");
   irq_reset_a: assert property (held_rst |-> status_change_irq_n_o) else $error("irq in reset");
   pin_reset_a: assert property (held_rst |-> data_oe_n_o) else $error("pin in reset");
   mode_move_a: assert property ($changed(i2c_mode_o) |-> core_reset_o || $past(core_reset_o))
      else $error("mode moved");
   irq_set_a: assert property (status_event_i |=> !status_change_irq_n_o) else $error("irq late");
   pin_two_a: assert property (!addr_hi_or_serial_out_oe_n_o |-> !i2c_mode_o) else $error("pin two");
   open_drain_a: assert property (i2c_mode_o && !data_oe_n_o |-> !data_o) else $error("data high");
   clk_edge_a: assert property (serial_clock_rise_o |-> serial_clock_o ##1 !serial_clock_rise_o)
      else $error("edge");
endmodule
bind hpc_pin_ctrl hpc_pin_ctrl_properties i_props (.clock_i, .rst_i, .status_event_i, .data_o, .data_oe_n_o,
   .addr_hi_or_serial_out_oe_n_o, .status_change_irq_n_o, .i2c_mode_o, .serial_clock_o, .serial_clock_rise_o,
   .core_reset_o, .clock_out_en_o);

// ### tb/hpc_host_model.sv
// ****
// Host controller model
// ****
module hpc_host_model (
   // Frame request and host pins
   input wire go_i,
   output logic clk_o = 1'b0,
   output logic cs_n_o = 1'b1
);
   timeunit 1ns;
   timeprecision 100ps;
   // select low, clock only in frame
   always @(posedge go_i) begin
      cs_n_o <= 1'b0;
      #37;
      repeat (4) begin
         #100 clk_o = 1'b1;
         #100 clk_o = 1'b0;
      end
      cs_n_o <= 1'b1;
   end
endmodule

// ### tb/host_port_pin_control_tb.sv
// ****
// Pin layer bench
// ****
module host_port_pin_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_i = 1'b0, rst_i, rst_n, oe1_n, mode_drv, oe1_drv, oe2_n, a_hi, a_lo, four, e_out, e_oe, ev, m1_wr;
   logic m2_wr, go;
   logic [7:0] n_rise = 8'h00;
   wire d_o, d_oe_n, ah_o, ah_oe_n, irq_n, mode, hclk, cs_n, rise, cs_o;
   wire [1:0] adr;
   wire [7:0] en;
   int failures, cmp_count;
   hpc_host_model i_host (.go_i(go), .clk_o(hclk), .cs_n_o(cs_n));
   hpc_pin_ctrl i_dut (.clock_i(clock_i), .rst_i(rst_i), .mode_sel_i(1'b0), .mode_sel_driven_i(mode_drv),
      .device_reset_n_i(rst_n), .output_enable_first_n_i(oe1_n), .output_enable_first_driven_i(oe1_drv),
      .output_enable_second_n_i(oe2_n), .serial_clock_i(hclk), .data_i(d_oe_n | d_o), .data_o(d_o),
      .data_oe_n_o(d_oe_n), .addr_hi_or_serial_out_i(ah_oe_n ? a_hi : ah_o), .addr_hi_or_serial_out_o(ah_o),
      .addr_hi_or_serial_out_oe_n_o(ah_oe_n), .addr_lo_or_chip_select_n_i(cs_n & a_lo),
      .addr_lo_or_chip_select_driven_i(1'b1), .status_change_irq_n_o(irq_n), .spi_four_wire_i(four),
      .eng_data_out_i(e_out), .eng_data_oe_i(e_oe), .eng_sdo_i(1'b1), .status_event_i(ev),
      .oe_first_map_i(8'h0f), .oe_first_map_wr_i(m1_wr), .oe_second_map_i(8'hf0), .oe_second_map_wr_i(m2_wr),
      .i2c_mode_o(mode), .serial_clock_o(), .serial_clock_rise_o(rise), .serial_clock_fall_o(), .data_in_o(),
      .chip_select_n_o(cs_o), .i2c_addr_low_o(adr), .core_reset_o(), .clock_out_en_o(en));
   // Sampled at the edge, before that edge's updates land
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      failures += (got !== exp);
      if (got !== exp) $display("BAD %0t %h %h", $time, got, exp);
   endtask
   task automatic final_report;
      if (failures == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial forever #12.5 clock_i = ~clock_i;
   always @(posedge clock_i) n_rise <= n_rise + {7'h00, rise === 1'b1};
   initial begin
      #20000 failures++;
      final_report();
   end
   initial begin
      {rst_i, rst_n, oe1_n, mode_drv, oe1_drv, oe2_n, a_hi, a_lo, four, e_out, e_oe, ev, m1_wr, m2_wr, go} = 15'h7000;
      cyc(20);
      rst_i <= 1'b0;
      cyc(4);
      chk({mode, irq_n, 6'h00, en}, 16'hc0ff);
      oe1_drv <= 1'b1;
      cyc(4);
      chk(en, 16'h0000);
      {oe1_n, oe2_n, e_oe, ev} <= 4'h7;
      cyc(1);
      ev <= 1'b0;
      cyc(3);
      chk({irq_n, d_oe_n, 6'h00, en}, 16'h00ff);
      {m2_wr, e_out, a_hi} <= 3'h7;
      cyc(1);
      m2_wr <= 1'b0;
      cyc(8);
      chk({irq_n, d_oe_n, adr, 4'h0, en}, 16'he00f);
      {m1_wr, oe1_n, oe2_n, a_hi, a_lo} <= 5'h19;
      cyc(1);
      m1_wr <= 1'b0;
      cyc(4);
      chk({6'h00, adr, en}, 16'h01f0);
      {mode_drv, four, oe1_n, oe2_n, rst_n} <= 5'h1a;
      cyc(6);
      chk(en, 16'h0000);
      rst_n <= 1'b1;
      cyc(6);
      chk({mode, 7'h00, en}, 16'h00ff);
      go <= 1'b1;
      cyc(8);
      chk({cs_o, ah_oe_n, ah_o, d_oe_n, 12'h000}, 16'h3000);
      four <= 1'b0;
      cyc(2);
      chk({d_oe_n, d_o, ah_oe_n}, 16'h0003);
      cyc(38);
      chk(n_rise, 16'h0004);
      final_report();
   end
endmodule
